// file: pgb_gpio_bank2.sv
// Second parallel GPIO bank: fourteen pins, direction and level registers
// Function
// - Pins 32..45 map in order to bits 0..13 of direction and level.
// - Direction bit one makes the pin an output, zero an input.
// - Reset clears all direction bits, so every pin starts as input.
// - Input pin: reading its level bit returns the present pin level.
// - Output pin: the pin is driven to the written level bit.
// - Level bits reset to the pin levels sampled as reset completes.
// - Function enable bit zero puts the pin in high impedance.
`timescale 1ns/1ps
`default_nettype none
module pgb_gpio_bank2 #(
	parameter int unsigned PINS = pgb_pkg::PIN_N // Pins in this bank
) (
	input  wire logic                       mclk,    // 40 MHz clock
	input  wire logic                       rst_n,   // Sync reset
	input  wire logic [pgb_pkg::AXI_AW-1:0] awaddr,  // Write address
	input  wire logic                       awvalid, // Write addr valid
	output var  logic                       awready, // Write addr ready
	input  wire logic [pgb_pkg::AXI_DW-1:0] wdata,   // Write data
	input  wire logic [pgb_pkg::AXI_SW-1:0] wstrb,   // Write strobes
	input  wire logic                       wvalid,  // Write data valid
	output var  logic                       wready,  // Write data ready
	output var  logic [1:0]                 bresp,   // Write response
	output var  logic                       bvalid,  // Write resp valid
	input  wire logic                       bready,  // Write resp ready
	input  wire logic [pgb_pkg::AXI_AW-1:0] araddr,  // Read address
	input  wire logic                       arvalid, // Read addr valid
	output var  logic                       arready, // Read addr ready
	output var  logic [pgb_pkg::AXI_DW-1:0] rdata,   // Read data
	output var  logic [1:0]                 rresp,   // Read response
	output var  logic                       rvalid,  // Read data valid
	input  wire logic                       rready,  // Read data ready
	input  wire logic [PINS-1:0]            pin_i,   // Pin levels in
	output var  logic [PINS-1:0]            pin_o,   // Pin levels out
	output var  logic [PINS-1:0]            pin_oe   // Pin drive enables
);
	import pgb_pkg::*;

	// Pins must fit below the reserved field
	if (PINS < 1 || PINS > RSV_LSB) begin : g_bad_pins
		$error("PINS must be 1 to 14");
	end

	pgb_reg_if rif ();

	logic [PINS-1:0]  pin_meta_r;
	logic [PINS-1:0]  pin_sync_r;
	logic [REG_W-1:0] dir_r;
	logic [REG_W-1:0] func_en_r;
	logic [REG_W-1:0] level_r;
	logic [REG_W-1:0] wr_mask;
	logic [REG_W-1:0] dir_nxt;
	logic [REG_W-1:0] func_en_nxt;
	logic [REG_W-1:0] level_nxt;
	logic [REG_W-1:0] pin_ext;
	logic [REG_W-1:0] keep_stored;
	logic [REG_W-1:0] level_view;
	logic             wr_dir;
	logic             wr_func_en;
	logic             wr_level;
	logic             rd_dir;
	logic             rd_func_en;
	logic             rd_level;

	pgb_axil_slave u_bus (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rif     (rif.bus)
	);

	// Two-stage synchroniser; left unreset so the pin level reaches level_r
	always_ff @(posedge mclk) begin
		pin_meta_r <= pin_i;
		pin_sync_r <= pin_meta_r;
	end

	// Address decode
	assign wr_dir     = rif.wr_en && (rif.wr_addr == ADDR_DIR);
	assign wr_func_en = rif.wr_en && (rif.wr_addr == ADDR_FUNC_EN);
	assign wr_level   = rif.wr_en && (rif.wr_addr == ADDR_LEVEL);
	assign rd_dir     = rif.rd_addr == ADDR_DIR;
	assign rd_func_en = rif.rd_addr == ADDR_FUNC_EN;
	assign rd_level   = rif.rd_addr == ADDR_LEVEL;
	assign rif.wr_hit = (rif.wr_addr == ADDR_DIR) ||
		(rif.wr_addr == ADDR_FUNC_EN) || (rif.wr_addr == ADDR_LEVEL);
	assign rif.rd_hit = rd_dir || rd_func_en || rd_level;

	// Byte-lane merge; all sixteen bits incl. reserved ones are stored
	assign wr_mask     = {{8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
	assign dir_nxt     = (dir_r & ~wr_mask) | (rif.wr_data & wr_mask);
	assign func_en_nxt = (func_en_r & ~wr_mask) | (rif.wr_data & wr_mask);
	assign level_nxt   = (level_r & ~wr_mask) | (rif.wr_data & wr_mask);

	// Input pins read their live level, outputs and spare bits the stored one
	assign pin_ext     = {{(REG_W-PINS){1'b0}}, pin_sync_r};
	assign keep_stored = {{(REG_W-PINS){1'b1}}, dir_r[PINS-1:0]};
	assign level_view  = (level_r & keep_stored) |
		(pin_ext & ~keep_stored);
	assign rif.rd_data = rd_dir ? dir_r :
		rd_func_en ? func_en_r :
		rd_level ? level_view : '0;

	// Direction and enable registers; every pin starts as a hi-Z input
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dir_r     <= DIR_RST;
			func_en_r <= FUNC_EN_RST;
		end else begin
			if (wr_dir)
				dir_r <= dir_nxt;
			if (wr_func_en)
				func_en_r <= func_en_nxt;
		end
	end

	// Level register tracks the pins while reset is held, so it holds them at release
	always_ff @(posedge mclk) begin
		if (!rst_n)
			level_r <= {RSV_RST, pin_ext[RSV_LSB-1:0]};
		else if (wr_level)
			level_r <= level_nxt;
	end

	// Pin drivers, registered; reserved bits never reach a pin
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_o  <= '0;
			pin_oe <= '0;
		end else begin
			pin_o  <= level_r[PINS-1:0];
			pin_oe <= dir_r[PINS-1:0] & func_en_r[PINS-1:0];
		end
	end

	// Every check runs on mclk and sleeps while reset is held
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	dir_reset_a:
	assert property ($rose(rst_n) |-> dir_r == DIR_RST && pin_oe == '0)
		else $error("direction not cleared by reset");

	level_reset_a:
	assert property ($rose(rst_n) |->
		level_r[PINS-1:0] == $past(pin_sync_r))
		else $error("level reset not the sampled pin level");

	// Stored values follow full-word writes
	dir_write_a:
	assert property (wr_dir && rif.wr_strb == 2'h3 |=>
		dir_r == $past(rif.wr_data))
		else $error("direction write not stored in order");

	enable_write_a:
	assert property (wr_func_en && rif.wr_strb == '1 |=>
		func_en_r == $past(rif.wr_data))
		else $error("enable write not stored");

	level_write_a:
	assert property (wr_level && rif.wr_strb == '1 |=>
		level_r == $past(rif.wr_data))
		else $error("level write not stored");

	// Reserved bits are plain storage and never reach a pin
	reserved_keep_a:
	assert property (wr_level && rif.wr_strb[1] |=>
		level_r[REG_W-1:RSV_LSB] == $past(rif.wr_data[REG_W-1:RSV_LSB]))
		else $error("reserved level bits not stored");

	dir_reserved_a:
	assert property (wr_dir && rif.wr_strb[1] |=>
		dir_r[REG_W-1:RSV_LSB] == $past(rif.wr_data[REG_W-1:RSV_LSB]))
		else $error("reserved direction bits not stored");

	// Unmapped writes must leave every register alone
	unmapped_keep_a:
	assert property (rif.wr_en && !rif.wr_hit |=>
		$stable(dir_r) && $stable(func_en_r) && $stable(level_r))
		else $error("unmapped write changed a register");

	// Read data seen at the port, one cycle after the address is taken
	input_read_a:
	assert property (arvalid && arready && rd_level |=>
		((rdata[PINS-1:0] ^ $past(pin_sync_r)) &
		~$past(dir_r[PINS-1:0])) == '0)
		else $error("input pin read not the pin level");

	rdata_upper_a:
	assert property (rvalid |-> rdata[AXI_DW-1:REG_W] == '0)
		else $error("read data upper half not zero");

	// Pin drivers trail their registers by one edge, reset edge excluded
	output_drive_a:
	assert property ($past(rst_n) |-> pin_o == $past(level_r[PINS-1:0]))
		else $error("output pin not driven to level bit");

	hiz_gate_a:
	assert property ($past(rst_n) |-> pin_oe ==
		($past(dir_r[PINS-1:0]) & $past(func_en_r[PINS-1:0])))
		else $error("pin drive not gated by direction and enable");

	// Main scenarios
	dir_write_c: cover property (wr_dir ##1 |dir_r);
	pin_drive_c: cover property (|pin_oe ##1 $changed(pin_o));
	input_read_c: cover property (rd_level && dir_r[PINS-1:0] == '0);
	enable_gate_c: cover property (|(dir_r[PINS-1:0] & ~func_en_r[PINS-1:0]));
	bad_write_c: cover property (rif.wr_en && !rif.wr_hit);
endmodule : pgb_gpio_bank2
`default_nettype wire

// file: pgb_pkg.sv
// Constants shared by the second parallel GPIO bank and its bus front end
`default_nettype none
package pgb_pkg;
	// Register geometry
	localparam int unsigned REG_W   = 16;
	localparam int unsigned PIN_N   = 14;
	localparam int unsigned RSV_LSB = 14;
	// Bus geometry
	localparam int unsigned AXI_AW  = 32;
	localparam int unsigned AXI_DW  = 32;
	localparam int unsigned AXI_SW  = 4;
	localparam int unsigned STRB_W  = 2;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_FUNC_EN = 16'h4406;
	localparam logic [15:0] IDX_DIR     = 16'h4407;
	localparam logic [15:0] IDX_LEVEL   = 16'h4408;
	localparam logic [31:0] ADDR_FUNC_EN = {14'h0000, IDX_FUNC_EN, 2'h0};
	localparam logic [31:0] ADDR_DIR     = {14'h0000, IDX_DIR, 2'h0};
	localparam logic [31:0] ADDR_LEVEL   = {14'h0000, IDX_LEVEL, 2'h0};
	// Reset values
	localparam logic [15:0] DIR_RST     = 16'h0000;
	localparam logic [15:0] FUNC_EN_RST = 16'h0000;
	localparam logic [1:0]  RSV_RST     = 2'h0;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : pgb_pkg
`default_nettype wire

// file: pgb_reg_if.sv
// Register access carrier between the bus front end and the bank logic
`timescale 1ns/1ps
`default_nettype none
interface pgb_reg_if;
	import pgb_pkg::*;
	logic              wr_en;   // One-cycle write strobe
	logic [AXI_AW-1:0] wr_addr; // Write byte address
	logic [REG_W-1:0]  wr_data; // Write data, low half word
	logic [STRB_W-1:0] wr_strb; // Byte lanes of the half word
	logic              wr_hit;  // Write address is mapped
	logic [AXI_AW-1:0] rd_addr; // Read byte address
	logic [REG_W-1:0]  rd_data; // Read value
	logic              rd_hit;  // Read address is mapped
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_hit, rd_data, rd_hit);
endinterface : pgb_reg_if
`default_nettype wire

// file: pgb_axil_slave.sv
// AXI4-Lite slave front end for the GPIO bank registers
`timescale 1ns/1ps
`default_nettype none
module pgb_axil_slave (
	input  wire logic                      mclk,    // 40 MHz clock
	input  wire logic                      rst_n,   // Sync reset
	input  wire logic [pgb_pkg::AXI_AW-1:0] awaddr, // Write address
	input  wire logic                      awvalid, // Write addr valid
	output var  logic                      awready, // Write addr ready
	input  wire logic [pgb_pkg::AXI_DW-1:0] wdata,  // Write data
	input  wire logic [pgb_pkg::AXI_SW-1:0] wstrb,  // Write strobes
	input  wire logic                      wvalid,  // Write data valid
	output var  logic                      wready,  // Write data ready
	output var  logic [1:0]                bresp,   // Write response
	output var  logic                      bvalid,  // Write resp valid
	input  wire logic                      bready,  // Write resp ready
	input  wire logic [pgb_pkg::AXI_AW-1:0] araddr, // Read address
	input  wire logic                      arvalid, // Read addr valid
	output var  logic                      arready, // Read addr ready
	output var  logic [pgb_pkg::AXI_DW-1:0] rdata,  // Read data
	output var  logic [1:0]                rresp,   // Read response
	output var  logic                      rvalid,  // Read data valid
	input  wire logic                      rready,  // Read data ready
	pgb_reg_if.bus                         rif      // Register side
);
	import pgb_pkg::*;

	logic              aw_full_r;
	logic              w_full_r;
	logic [AXI_AW-1:0] awaddr_r;
	logic [REG_W-1:0]  wdata_r;
	logic [STRB_W-1:0] wstrb_r;
	logic              aw_take;
	logic              w_take;
	logic              b_done;
	logic              do_wr;
	logic              ar_take;
	logic              r_done;

	// Handshake decode; a write fires once both halves are held
	assign aw_take = awvalid && awready;
	assign w_take  = wvalid && wready;
	assign b_done  = bvalid && bready;
	assign do_wr   = aw_full_r && w_full_r && !bvalid;
	assign ar_take = arvalid && arready;
	assign r_done  = rvalid && rready;

	// Register side view
	assign rif.wr_en   = do_wr;
	assign rif.wr_addr = awaddr_r;
	assign rif.wr_data = wdata_r;
	assign rif.wr_strb = wstrb_r;
	assign rif.rd_addr = araddr;

	// Write address and data latches, taken in either order
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
		end else begin
			if (aw_take) begin
				aw_full_r <= 1'b1;
				awaddr_r  <= awaddr;
			end
			if (w_take) begin
				w_full_r <= 1'b1;
				wdata_r  <= wdata[REG_W-1:0];
				wstrb_r  <= wstrb[STRB_W-1:0];
			end
			if (do_wr) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
			end
		end
	end

	// Write response; readies return only after the response, one write at a time
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (aw_take)
				awready <= 1'b0;
			if (w_take)
				wready <= 1'b0;
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp  <= rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_done) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read channel, answered the cycle after the address is taken
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {{(AXI_DW-REG_W){1'b0}}, rif.rd_data};
			rresp   <= rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (r_done) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	bvalid_hold_a:
	assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");
	read_latency_a:
	assert property (ar_take |=> rvalid && !arready)
		else $error("read answer not one cycle after address");
	unmapped_resp_a:
	assert property (ar_take && !rif.rd_hit |=> rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule : pgb_axil_slave
`default_nettype wire

// file: pgb_pin_model.sv
// Pin-side model of the second GPIO bank's external pins
`timescale 1ns/1ps
`default_nettype none
module pgb_pin_model (
	input  wire logic        mclk,   // Bank clock
	input  wire logic [13:0] ext_v,  // Level driven from outside
	input  wire logic [13:0] ext_en, // Outside drive enables
	input  wire logic [13:0] pin_o,  // Device drive level
	input  wire logic [13:0] pin_oe, // Device drive enables
	output wire logic [13:0] pin_i   // Resolved wire level
);
	logic [13:0] float_r = 14'h1555; // Undriven lines never hold a level

	// Floating lines wander so a stale value never reads as good
	always @(posedge mclk) begin
		float_r <= ~float_r;
	end

	// Device drive wins; outside drivers act on undriven pins only
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_v)
		| (~pin_oe & ~ext_en & float_r);
endmodule : pgb_pin_model
`default_nettype wire

// file: parallel_gpio_bank_two_bench.sv
// Self-checking bench for the second parallel GPIO bank
`timescale 1ns/1ps
`default_nettype none
module parallel_gpio_bank_two_bench;
	import pgb_pkg::*;
	logic        mclk    = 1'b0;
	logic        rst_n   = 1'b0;
	logic [31:0] awaddr  = 32'h0;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] araddr  = 32'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [13:0] ext_v   = 14'h2a5c;
	logic [13:0] ext_en  = 14'h3fff;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [13:0] pin_i, pin_o, pin_oe;
	int          num_errors = 0;
	int          checks = 0;

	// Bench clock, 25 ns period
	always #12.5 mclk = ~mclk;

	// Design and its pins
	pgb_gpio_bank2 #(.PINS(PIN_N)) i_dut (.mclk(mclk), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
	pgb_pin_model i_pins (.mclk(mclk), .ext_v(ext_v), .ext_en(ext_en),
		.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

	task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t value %h expected %h", $time, g, e);
		end
	endtask : chk_d

	task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t response %h expected %h", $time, g, e);
		end
	endtask : chk_r

	// Bounded wait step; a hang ends the run
	task automatic tmo(inout int n);
		n++;
		if (n > 64) begin
			num_errors++;
			$display("MISMATCH %0t bus handshake timed out", $time);
			close_out();
		end
	endtask : tmo

	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		bit ta;
		bit tw;
		n = 0;
		ta = 0;
		tw = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge mclk);
			tmo(n);
			if (!ta && awready === 1'b1) begin
				ta = 1;
				awvalid <= 1'b0;
			end
			if (!tw && wready === 1'b1) begin
				tw = 1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge mclk);
			tmo(n);
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk_r(bresp, er);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			tmo(n);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge mclk);
			tmo(n);
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk_d(rdata, e);
		chk_r(rresp, er);
	endtask : rd

	task automatic done(input string t);
		$display("test %s finished, errors so far %0d", t, num_errors);
	endtask : done

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// Main sequence
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		rd(ADDR_DIR, 32'h0, RESP_OKAY);
		rd(ADDR_LEVEL, 32'h2a5c, RESP_OKAY);
		rd(ADDR_FUNC_EN, 32'h0, RESP_OKAY);
		chk_d({18'h0, pin_oe}, 32'h0);
		// Stored reset level shows once pins turn output, still hi-Z
		ext_v <= 14'h15a3;
		wr(ADDR_DIR, 32'h3fff, 4'hf, RESP_OKAY);
		rd(ADDR_LEVEL, 32'h2a5c, RESP_OKAY);
		chk_d({18'h0, pin_oe}, 32'h0);
		wr(ADDR_DIR, 32'h0, 4'hf, RESP_OKAY);
		done("reset");
		// One high pin walks across the bank
		for (int k = 0; k < 14; k++) begin
			ext_v <= 14'h1 << k;
			repeat (3) @(posedge mclk);
			rd(ADDR_LEVEL, 32'h1 << k, RESP_OKAY);
		end
		ext_v <= 14'h1234;
		done("input");
		wr(ADDR_FUNC_EN, 32'h3fff, 4'hf, RESP_OKAY);
		wr(ADDR_DIR, 32'h00ff, 4'hf, RESP_OKAY);
		wr(ADDR_LEVEL, 32'h3ca5, 4'hf, RESP_OKAY);
		repeat (2) @(negedge mclk);
		chk_d({18'h0, pin_oe}, 32'h00ff);
		chk_d({18'h0, pin_o & pin_oe}, 32'h00a5);
		rd(ADDR_LEVEL, 32'h12a5, RESP_OKAY);
		wr(ADDR_LEVEL, 32'hff00, 4'h1, RESP_OKAY);
		repeat (2) @(negedge mclk);
		chk_d({18'h0, pin_o & pin_oe}, 32'h0);
		done("output");
		wr(ADDR_FUNC_EN, 32'h00f0, 4'hf, RESP_OKAY);
		repeat (2) @(negedge mclk);
		chk_d({18'h0, pin_oe}, 32'h00f0);
		done("enable");
		// Upper lane only: reserved bits set, low byte untouched
		wr(ADDR_DIR, 32'hc011, 4'h2, RESP_OKAY);
		rd(ADDR_DIR, 32'hc0ff, RESP_OKAY);
		repeat (2) @(negedge mclk);
		chk_d({18'h0, pin_oe}, 32'h00f0);
		done("reserved");
		wr(ADDR_DIR + 32'h2, 32'h0, 4'hf, RESP_SLVERR);
		rd(ADDR_DIR, 32'hc0ff, RESP_OKAY);
		rd(ADDR_LEVEL + 32'h4, 32'h0, RESP_SLVERR);
		done("unmapped");
		// Reset again mid-run on fresh pin levels
		@(posedge mclk);
		rst_n <= 1'b0;
		ext_v <= 14'h0c3a;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		rd(ADDR_DIR, 32'h0, RESP_OKAY);
		chk_d({18'h0, pin_oe}, 32'h0);
		ext_v <= 14'h3333;
		wr(ADDR_DIR, 32'h3fff, 4'hf, RESP_OKAY);
		rd(ADDR_LEVEL, 32'h0c3a, RESP_OKAY);
		done("rerun");
		close_out();
	end
endmodule : parallel_gpio_bank_two_bench
`default_nettype wire
